// ===== aocf_consts.svh
// Constants for the sample word formatter: code widths, full-scale codes and latency.
// Assumes inclusion by the package and the design modules of this block only.
`ifndef AOCF_CONSTS_SVH
`define AOCF_CONSTS_SVH

`define AOCF_WORD_W 10
`define AOCF_STAGE_BITS 2
`define AOCF_STAGE_CNT 9
`define AOCF_SUM_W 11
`define AOCF_MSB_POS 9
`define AOCF_POS_FS_BIN 10'h3FF
`define AOCF_NEG_FS_BIN 10'h000
`define AOCF_LATENCY_CYC 8
`define AOCF_DELAY_STAGES (`AOCF_LATENCY_CYC - 2)
`define AOCF_BUF_DEPTH 2
`define AOCF_FMT_TWOS 1'b0
`define AOCF_FMT_OFFSET 1'b1

`endif

// ===== aocf_pkg.sv
// Types used by the sample word formatter; its output buffer is generic and does not use them.
// Assumes the constants header is on the include path.
`include "aocf_consts.svh"

package aocf_pkg;

    // One formatted conversion result with its range flag.
    typedef struct packed {
        logic [`AOCF_WORD_W-1:0] code;
        logic out_of_range;
    } aocf_word_t;

    // Raw capture of one sampling edge before correction.
    typedef struct packed {
        logic [`AOCF_STAGE_CNT*`AOCF_STAGE_BITS-1:0] stage_codes;
        logic over_fs;
        logic under_fs;
        logic fmt_offset;
    } aocf_capture_t;

endpackage

// ===== aocf_word_buffer.sv
// Small FIFO of flip-flops with valid and ready on both sides.
// Assumes both sides run on ref_clk; read data is a mux of the storage flops.
`timescale 1ns/1ps

module aocf_word_buffer #(
    parameter int WIDTH = 11,
    parameter int DEPTH = 2
) (
    input wire logic ref_clk,
    input wire logic rst,
    input wire logic wr_valid,
    output logic wr_ready,
    input wire logic [WIDTH-1:0] wr_data,
    output logic rd_valid,
    input wire logic rd_ready,
    output logic [WIDTH-1:0] rd_data
);
    localparam int PW = (DEPTH > 1) ? $clog2(DEPTH) : 1;

    logic [WIDTH-1:0] mem_ff [DEPTH];
    logic [PW-1:0] wr_ptr_ff;
    logic [PW-1:0] rd_ptr_ff;
    logic [PW:0] count_ff;
    logic do_wr;
    logic do_rd;

    // Full and empty come straight from the count, so back-pressure is exact.
    assign wr_ready = (count_ff != (PW+1)'(DEPTH));
    assign rd_valid = (count_ff != '0);
    assign rd_data = mem_ff[rd_ptr_ff];
    assign do_wr = wr_valid && wr_ready;
    assign do_rd = rd_valid && rd_ready;

    always_ff @(posedge ref_clk) begin
        if (do_wr) begin
            mem_ff[wr_ptr_ff] <= wr_data;
        end
    end

    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            wr_ptr_ff <= '0;
            rd_ptr_ff <= '0;
            count_ff <= '0;
        end else begin
            if (do_wr) begin
                wr_ptr_ff <= (wr_ptr_ff == PW'(DEPTH-1)) ? '0 : wr_ptr_ff + PW'(1);
            end
            if (do_rd) begin
                rd_ptr_ff <= (rd_ptr_ff == PW'(DEPTH-1)) ? '0 : rd_ptr_ff + PW'(1);
            end
            if (do_wr && !do_rd) begin
                count_ff <= count_ff + (PW+1)'(1);
            end else if (do_rd && !do_wr) begin
                count_ff <= count_ff - (PW+1)'(1);
            end
        end
    end

endmodule // aocf_word_buffer

// ===== aocf_formatter.sv
// Digital back end of a pipelined converter: correction, coding, range flag and output.
// Assumes ref_clk is the conversion clock and stage codes settle before each rising edge.
`timescale 1ns/1ps
`include "aocf_consts.svh"

module aocf_formatter #(
    parameter int STAGES = `AOCF_STAGE_CNT,
    parameter int DELAY = `AOCF_DELAY_STAGES,
    parameter int BUF_DEPTH = `AOCF_BUF_DEPTH
) (
    input wire logic ref_clk,
    input wire logic rst,
    input wire logic [STAGES*`AOCF_STAGE_BITS-1:0] stage_codes,
    input wire logic over_fs,
    input wire logic under_fs,
    input wire logic format_select,
    input wire logic half_rate_select,
    input wire logic rcv_ready,
    output logic [`AOCF_WORD_W-1:0] sample_word_pairs_true,
    output logic [`AOCF_WORD_W-1:0] sample_word_pairs_comp,
    output logic range_flag_true,
    output logic range_flag_comp,
    output logic word_strobe_true,
    output logic word_strobe_comp
);
    localparam int WW = `AOCF_WORD_W;
    localparam int BW = $bits(aocf_pkg::aocf_word_t);

    // ------------------------------------------------------------------
    // Pin synchronisers
    // ------------------------------------------------------------------
    // A change is accepted only when the second and third stages agree.
    logic [2:0] fmt_sync_ff;
    logic [2:0] rate_sync_ff;
    logic fmt_sel_ff;
    logic full_rate_ff;

    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            fmt_sync_ff <= 3'h0;
            rate_sync_ff <= 3'h0;
        end else begin
            fmt_sync_ff <= {fmt_sync_ff[1:0], format_select};
            rate_sync_ff <= {rate_sync_ff[1:0], half_rate_select};
        end
    end

    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            fmt_sel_ff <= `AOCF_FMT_TWOS;
            full_rate_ff <= 1'b0;
        end else begin
            if (fmt_sync_ff[1] == fmt_sync_ff[2]) begin
                fmt_sel_ff <= fmt_sync_ff[2];
            end
            if (rate_sync_ff[1] == rate_sync_ff[2]) begin
                full_rate_ff <= rate_sync_ff[2];
            end
        end
    end

    // ------------------------------------------------------------------
    // Sampling
    // ------------------------------------------------------------------
    logic stall;
    logic phase_ff;
    logic take_sample;
    aocf_pkg::aocf_capture_t cap_ff;
    logic cap_valid_ff;

    // The pipeline cannot refuse the analog side, so a full buffer freezes it
    // and the edges that arrive meanwhile are not converted.
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            phase_ff <= 1'b0;
        end else begin
            phase_ff <= ~phase_ff;
        end
    end

    assign take_sample = full_rate_ff || !phase_ff;

    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            cap_ff <= '0;
            cap_valid_ff <= 1'b0;
        end else if (!stall) begin
            cap_ff.stage_codes <= stage_codes;
            cap_ff.over_fs <= over_fs;
            cap_ff.under_fs <= under_fs;
            cap_ff.fmt_offset <= fmt_sel_ff;
            cap_valid_ff <= take_sample;
        end
    end

    // ------------------------------------------------------------------
    // Correction and coding
    // ------------------------------------------------------------------
    // Each stage overlaps the next by one bit, so stage i weighs 2^(STAGES-1-i).
    function automatic logic [`AOCF_SUM_W-1:0] correct(
        input logic [STAGES*`AOCF_STAGE_BITS-1:0] codes
    );
        logic [`AOCF_SUM_W-1:0] acc;
        acc = '0;
        for (int i = 0; i < STAGES; i++) begin
            acc = (acc << 1) + `AOCF_SUM_W'(codes[(STAGES-1-i)*`AOCF_STAGE_BITS +: 2]);
        end
        return acc;
    endfunction

    logic [`AOCF_SUM_W-1:0] sum;
    logic [WW-1:0] bin_code;
    logic range_hit;
    aocf_pkg::aocf_word_t coded;

    always_comb begin
        sum = correct(cap_ff.stage_codes);
        range_hit = cap_ff.over_fs || cap_ff.under_fs;
        if (cap_ff.over_fs) begin
            bin_code = `AOCF_POS_FS_BIN;
        end else if (cap_ff.under_fs) begin
            bin_code = `AOCF_NEG_FS_BIN;
        end else if (sum > `AOCF_SUM_W'(`AOCF_POS_FS_BIN)) begin
            bin_code = `AOCF_POS_FS_BIN;
        end else begin
            bin_code = sum[WW-1:0];
        end
        coded.code = bin_code;
        if (cap_ff.fmt_offset == `AOCF_FMT_TWOS) begin
            coded.code[`AOCF_MSB_POS] = ~bin_code[`AOCF_MSB_POS];
        end
        coded.out_of_range = range_hit;
    end

    // ------------------------------------------------------------------
    // Latency line
    // ------------------------------------------------------------------
    aocf_pkg::aocf_word_t line_ff [DELAY];
    logic [DELAY-1:0] line_valid_ff;

    genvar g;
    generate
        for (g = 0; g < DELAY; g++) begin : g_line
            always_ff @(posedge ref_clk or posedge rst) begin
                if (rst) begin
                    line_ff[g] <= '0;
                    line_valid_ff[g] <= 1'b0;
                end else if (!stall) begin
                    line_ff[g] <= (g == 0) ? coded : line_ff[(g == 0) ? 0 : g-1];
                    line_valid_ff[g] <= (g == 0) ? cap_valid_ff
                                                 : line_valid_ff[(g == 0) ? 0 : g-1];
                end
            end
        end
    endgenerate

    // ------------------------------------------------------------------
    // Buffer and output stage
    // ------------------------------------------------------------------
    logic buf_wr_ready;
    logic buf_rd_valid;
    logic buf_rd_ready;
    logic [BW-1:0] buf_rd_data;
    aocf_pkg::aocf_word_t head;
    logic out_valid_ff;

    assign stall = !buf_wr_ready;
    assign head = aocf_pkg::aocf_word_t'(buf_rd_data);
    assign buf_rd_ready = !out_valid_ff || rcv_ready;

    aocf_word_buffer #(
        .WIDTH(BW),
        .DEPTH(BUF_DEPTH)
    ) u_buf (
        .ref_clk(ref_clk),
        .rst(rst),
        .wr_valid(line_valid_ff[DELAY-1]),
        .wr_ready(buf_wr_ready),
        .wr_data(line_ff[DELAY-1]),
        .rd_valid(buf_rd_valid),
        .rd_ready(buf_rd_ready),
        .rd_data(buf_rd_data)
    );

    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            out_valid_ff <= 1'b0;
        end else if (buf_rd_ready) begin
            out_valid_ff <= buf_rd_valid;
        end
    end

    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            sample_word_pairs_true <= '0;
            sample_word_pairs_comp <= '1;
        end else if (buf_rd_ready && buf_rd_valid) begin
            sample_word_pairs_true <= head.code;
            sample_word_pairs_comp <= ~head.code;
        end
    end

    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            range_flag_true <= 1'b0;
            range_flag_comp <= 1'b1;
        end else if (buf_rd_ready && buf_rd_valid) begin
            range_flag_true <= head.out_of_range;
            range_flag_comp <= ~head.out_of_range;
        end
    end

    assign word_strobe_true = out_valid_ff;
    assign word_strobe_comp = ~out_valid_ff;

endmodule // aocf_formatter

// ===== aocf_formatter_chk.sv
// Concurrent checks on the formatter ports, bound into every formatter instance.
// Assumes one clock domain and a receiver that only stalls with in-range traffic.
`timescale 1ns/1ps
module aocf_formatter_chk #(
    parameter int STAGES = 9,
    parameter int DELAY = 6,
    parameter int BUF_DEPTH = 2
) (
    input wire logic ref_clk,
    input wire logic rst,
    input wire logic [STAGES*2-1:0] stage_codes,
    input wire logic over_fs,
    input wire logic under_fs,
    input wire logic format_select,
    input wire logic half_rate_select,
    input wire logic rcv_ready,
    input wire logic [9:0] sample_word_pairs_true,
    input wire logic [9:0] sample_word_pairs_comp,
    input wire logic range_flag_true,
    input wire logic range_flag_comp,
    input wire logic word_strobe_true,
    input wire logic word_strobe_comp
);
    default clocking @(posedge ref_clk); endclocking
    default disable iff (rst);
    // Five cycles of settled pins cover the three-stage pin synchroniser.
    property p_fmt(f, c, logic [9:0] w);
        (half_rate_select && format_select == f) [*5] ##0 c && rcv_ready ##1 rcv_ready [*8]
            |=> sample_word_pairs_true == w;
    endproperty
    pair_inv_a: assert property (sample_word_pairs_comp == ~sample_word_pairs_true
        && range_flag_comp != range_flag_true && word_strobe_comp != word_strobe_true)
        else $error("complement outputs disagree");
    stall_hold_a: assert property (word_strobe_true && !rcv_ready |=> word_strobe_true
        && $stable(sample_word_pairs_true) && $stable(range_flag_true))
        else $error("word changed while stalled");
    clamp_code_a: assert property (word_strobe_true && range_flag_true |->
        sample_word_pairs_true inside {10'h3ff, 10'h1ff, 10'h000, 10'h200})
        else $error("flagged word not a full scale code");
    flag_set_a: assert property (half_rate_select [*5] ##0 (over_fs || under_fs)
        && rcv_ready ##1 rcv_ready [*8] |=> range_flag_true && word_strobe_true)
        else $error("range flag missing eight cycles on");
    flag_clear_a: assert property (half_rate_select [*5] ##0 !over_fs && !under_fs
        && rcv_ready ##1 rcv_ready [*8] |=> !range_flag_true && word_strobe_true)
        else $error("range flag set for in-range sample");
    pos_bin_a: assert property (p_fmt(1'b1, over_fs, 10'h3ff))
        else $error("positive clamp wrong in offset binary");
    pos_twos_a: assert property (p_fmt(1'b0, over_fs, 10'h1ff))
        else $error("positive clamp wrong in twos complement");
    neg_bin_a: assert property (p_fmt(1'b1, under_fs && !over_fs, 10'h000))
        else $error("negative clamp wrong in offset binary");
    neg_twos_a: assert property (p_fmt(1'b0, under_fs && !over_fs, 10'h200))
        else $error("negative clamp wrong in twos complement");
    early_strobe_a: assert property ($fell(rst) |-> !word_strobe_true [*8])
        else $error("word strobe before pipeline filled");
    half_gap_a: assert property ((!half_rate_select) [*8] ##1
        (!half_rate_select && rcv_ready) [*8] ##0 word_strobe_true |=> !word_strobe_true)
        else $error("back to back words at half rate");
    cover property (word_strobe_true && !rcv_ready);
    cover property (word_strobe_true && range_flag_true);
    cover property (!half_rate_select && word_strobe_true);
endmodule // aocf_formatter_chk

bind aocf_formatter aocf_formatter_chk #(.STAGES(STAGES), .DELAY(DELAY), .BUF_DEPTH(BUF_DEPTH))
    aocf_formatter_chk_inst (.ref_clk(ref_clk), .rst(rst), .stage_codes(stage_codes),
    .over_fs(over_fs), .under_fs(under_fs), .format_select(format_select),
    .half_rate_select(half_rate_select), .rcv_ready(rcv_ready),
    .sample_word_pairs_true(sample_word_pairs_true),
    .sample_word_pairs_comp(sample_word_pairs_comp), .range_flag_true(range_flag_true),
    .range_flag_comp(range_flag_comp), .word_strobe_true(word_strobe_true),
    .word_strobe_comp(word_strobe_comp));

// ===== aocf_rx_model.sv
// Receiver model that latches each word the formatter offers.
// Assumes the bench raises hold only when a stall is wanted.
`timescale 1ns/1ps
module aocf_rx_model (
    input wire logic ref_clk,
    input wire logic rst,
    input wire logic hold,
    input wire logic strobe,
    input wire logic flag,
    input wire logic [9:0] word,
    output logic rcv_ready
);
    logic [10:0] got[$];
    assign rcv_ready = !hold;
    always @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            got.delete();
        end else if (strobe && rcv_ready) begin
            got.push_back({flag, word});
        end
    end
endmodule // aocf_rx_model

// ===== tb.sv
// Self-checking bench for the formatter with a receiver model.
// Assumes stage code 0 is the most significant stage and weights halve per stage.
`timescale 1ns/1ps
module tb;
    logic ref_clk, rst, over_fs, under_fs, format_select, half_rate_select, rcv_ready, hold;
    logic [17:0] stage_codes;
    logic [9:0] sample_word_pairs_true, sample_word_pairs_comp;
    logic range_flag_true, range_flag_comp, word_strobe_true, word_strobe_comp;
    int errors, compares;
    aocf_formatter aocf_formatter_inst (.ref_clk(ref_clk), .rst(rst),
        .stage_codes(stage_codes), .over_fs(over_fs), .under_fs(under_fs),
        .format_select(format_select), .half_rate_select(half_rate_select),
        .rcv_ready(rcv_ready), .sample_word_pairs_true(sample_word_pairs_true),
        .sample_word_pairs_comp(sample_word_pairs_comp), .range_flag_true(range_flag_true),
        .range_flag_comp(range_flag_comp), .word_strobe_true(word_strobe_true),
        .word_strobe_comp(word_strobe_comp));
    aocf_rx_model aocf_rx_model_inst (.ref_clk(ref_clk), .rst(rst), .hold(hold),
        .strobe(word_strobe_true), .flag(range_flag_true), .word(sample_word_pairs_true),
        .rcv_ready(rcv_ready));
    initial begin
        ref_clk = 0;
        forever #2 ref_clk = ~ref_clk;
    end
    function automatic logic [10:0] expw(logic [19:0] v, logic f);
        int s;
        logic [9:0] c;
        s = 0;
        for (int i = 0; i < 9; i++) s += int'(v[17-2*i -: 2]) << (8 - i);
        c = (s > 1023) ? 10'h3ff : s[9:0];
        if (v[19]) c = 10'h3ff;
        else if (v[18]) c = 10'h000;
        if (!f) c[9] = ~c[9];
        return {v[19] | v[18], c};
    endfunction
    function automatic void dd(ref logic [10:0] q[$]);
        for (int i = q.size() - 1; i > 0; i--) if (q[i] === q[i-1]) q.delete(i);
    endfunction
    task cmp(input logic [11:0] g, input logic [11:0] e, input string m);
        compares++;
        if (g !== e) begin
            errors++;
            $display("MISMATCH t=%0t %s got %h exp %h", $time, m, g, e);
        end
    endtask
    task drv(input logic [19:0] v, input int n);
        {over_fs, under_fs, stage_codes} = v;
        repeat (n) @(posedge ref_clk);
        #1;
    endtask
    // Inputs stay idle around the burst, so repeated words collapse to one entry each.
    task automatic run(input logic f, input logic h, input logic st, input logic [19:0] vs[$]);
        logic [10:0] e[$];
        logic [10:0] g[$];
        format_select = f;
        half_rate_select = h;
        drv(20'h0_0000, 16);
        aocf_rx_model_inst.got.delete();
        e.push_back(expw(20'h0_0000, f));
        foreach (vs[i]) begin
            drv(vs[i], h ? 1 : 2);
            e.push_back(expw(vs[i], f));
        end
        hold = st;
        drv(20'h0_0000, 12);
        hold = 0;
        drv(20'h0_0000, 24);
        e.push_back(expw(20'h0_0000, f));
        g = aocf_rx_model_inst.got;
        dd(e);
        dd(g);
        cmp(12'(g.size()), 12'(e.size()), "word count");
        foreach (e[i]) cmp({1'b0, g[i]}, {1'b0, e[i]}, "word");
    endtask
    task t_codes;
        run(1, 1, 0, '{20'h1_5555, 20'h2_aaaa, 20'h3_ffff, 20'h2_0000, 20'h0_0001});
        run(0, 1, 0, '{20'h1_5555, 20'h2_aaaa, 20'h3_ffff, 20'h2_0000, 20'h0_0001});
        $display("t_codes done");
    endtask
    task t_reset;
        drv(20'h1_5555, 1);
        rst = 1;
        drv(20'h1_5555, 2);
        cmp({word_strobe_true, range_flag_comp, sample_word_pairs_comp}, 12'h7ff, "reset");
        cmp({1'b0, range_flag_true, sample_word_pairs_true}, 12'h000, "reset true");
        rst = 0;
        $display("t_reset done");
    endtask
    task t_half;
        run(1, 0, 0, '{20'h1_5555, 20'h0_0001, 20'h2_aaaa, 20'h3_ffff});
        $display("t_half done");
    endtask
    task t_range;
        run(1, 1, 0, '{20'h8_0000, 20'h1_5555, 20'h4_0000, 20'hc_0000});
        run(0, 1, 0, '{20'h8_0000, 20'h1_5555, 20'h4_0000, 20'hc_0000});
        $display("t_range done");
    endtask
    task t_stall;
        run(0, 1, 1, '{20'h0_0011, 20'h2_aaaa, 20'h1_5555, 20'h0_0100});
        $display("t_stall done");
    endtask
    task print_verdict;
        $display("errors=%0d compares=%0d", errors, compares);
        if (errors == 0 && compares > 0) $display("Test passed");
        else $display("Test failed");
        $finish;
    endtask
    initial begin
        rst = 1;
        hold = 0;
        {over_fs, under_fs, stage_codes} = 20'h0_0000;
        format_select = 0;
        half_rate_select = 1;
        repeat (3) @(posedge ref_clk);
        #1;
        rst = 0;
        t_codes();
        t_reset();
        t_half();
        t_range();
        t_stall();
        print_verdict();
    end
    // The runs take about three hundred and fifty cycles; this cuts a hang well past that.
    initial begin
        #20000;
        errors++;
        print_verdict();
    end
endmodule // tb
